// *** cat_defs.svh ***
/*
  register map, field positions, reset values and divider counts of the
  counter array timebase. assumes an 8-bit register port.
*/
`ifndef CAT_DEFS_SVH
`define CAT_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CAT_ADDR_CTRL 8'hd8
`define CAT_ADDR_MODE 8'hd9
`define CAT_ADDR_CNT_LO 8'he9
`define CAT_ADDR_CNT_HI 8'hf9

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CAT_CTRL_OVF 7
`define CAT_CTRL_CR 6
`define CAT_MODE_IDLE 7
`define CAT_MODE_SEL_HI 3
`define CAT_MODE_SEL_LO 1
`define CAT_MODE_OVF_IE 0
`define CAT_MODE_MASK 8'h8f
`define CAT_REG_RESET 8'h00
`define CAT_CNT_RESET 16'h0000
`define CAT_CNT_MAX 16'hffff
`define CAT_CNT_ONE 16'h0001
`define CAT_READ_ZERO 8'h00

// ----------------------------------------------------------------------
// timebase divider counts
// ----------------------------------------------------------------------
`define CAT_DIV_SLOW 12
`define CAT_DIV_FAST 4
`define CAT_DIV_OSC 8

`endif

// *** cat_pkg.sv ***
/*
  types shared by the counter array timebase.
  assumes cat_defs.svh for numeric constants.
*/
`default_nettype none
package cat_pkg;

  // timebase encodings of the select field
  typedef enum logic [2:0] {
    CAT_TB_DIV12 = 3'h0,
    CAT_TB_DIV4 = 3'h1,
    CAT_TB_TMR0 = 3'h2,
    CAT_TB_EXT = 3'h3,
    CAT_TB_SYS = 3'h4,
    CAT_TB_OSC8 = 3'h5
  } cat_tb_t;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cat_bus_t;

endpackage
`default_nettype wire

// *** cat_timebase.sv ***
/*
  16-bit counter array timebase with selectable increment source, low-byte
  snapshot read, overflow flag and gated interrupt request.
  assumes a register port with single-cycle strobes and all inputs
  synchronous to sys_clk, except osc_clk which is resynchronised here.
*/
//
// Notes on behaviour
// - count is two bytes, high and low
// - low read latches high byte for next read
// - read low first; reads never disturb counting
// - select field picks one of six timebases
// - external input counts falling edges, max sys/4
// - oscillator divided by eight, synchronised first
// - wrap from all ones sets overflow flag
// - interrupt only when overflow enable set
// - flag stays set; software clears it
// - global and array enables also required
// - idle suspend clear keeps counting in idle
`timescale 1ns/10ps
`default_nettype none
`include "cat_defs.svh"

module cat_timebase #(
  parameter int DIV_SLOW = `CAT_DIV_SLOW,
  parameter int DIV_FAST = `CAT_DIV_FAST,
  parameter int DIV_OSC = `CAT_DIV_OSC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input var cat_pkg::cat_bus_t bus,
  output logic [7:0] rd_data,
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic osc_clk,
  input wire logic cpu_idle,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  output logic irq
);

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic wr_ctrl, wr_mode, wr_lo, wr_hi, rd_lo, rd_hi;
  assign wr_ctrl = bus.wr && hit(bus.addr, `CAT_ADDR_CTRL);
  assign wr_mode = bus.wr && hit(bus.addr, `CAT_ADDR_MODE);
  assign wr_lo = bus.wr && hit(bus.addr, `CAT_ADDR_CNT_LO);
  assign wr_hi = bus.wr && hit(bus.addr, `CAT_ADDR_CNT_HI);
  assign rd_lo = bus.rd && hit(bus.addr, `CAT_ADDR_CNT_LO);
  assign rd_hi = bus.rd && hit(bus.addr, `CAT_ADDR_CNT_HI);

  // ----------------------------------------------------------------------
  // timebase sources
  // ----------------------------------------------------------------------
  logic [3:0] slow_q, slow_d;
  logic [2:0] fast_q, fast_d;
  logic [2:0] osc_cnt_q, osc_cnt_d;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic ext_prev_q;
  logic slow_tick, fast_tick, osc_tick, ext_tick;

  always_comb begin
    slow_tick = (slow_q == 4'(DIV_SLOW - 1));
    fast_tick = (fast_q == 3'(DIV_FAST - 1));
    slow_d = slow_tick ? 4'h0 : slow_q + 4'h1;
    fast_d = fast_tick ? 3'h0 : fast_q + 3'h1;
    // divided oscillator: count rising edges of the resynchronised clock
    osc_tick = 1'b0;
    osc_cnt_d = osc_cnt_q;
    if (osc_s2_q && !osc_s3_q) begin
      if (osc_cnt_q == 3'(DIV_OSC - 1)) begin
        osc_cnt_d = 3'h0;
        osc_tick = 1'b1;
      end else begin
        osc_cnt_d = osc_cnt_q + 3'h1;
      end
    end
    ext_tick = ext_prev_q && !external_count_input;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slow_q <= 4'h0;
      fast_q <= 3'h0;
      osc_cnt_q <= 3'h0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      ext_prev_q <= 1'b1;
    end else begin
      slow_q <= slow_d;
      fast_q <= fast_d;
      osc_cnt_q <= osc_cnt_d;
      // two-flop synchroniser; only osc_s2_q onward is looked at
      osc_s1_q <= osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      ext_prev_q <= external_count_input;
    end
  end

  // ----------------------------------------------------------------------
  // counter, registers and interrupt
  // ----------------------------------------------------------------------
  logic [15:0] count_q, count_d;
  logic [7:0] snap_q, snap_d;
  logic [7:0] mode_q, mode_d;
  logic ovf_flag_q, ovf_flag_d, cr_q, cr_d;
  logic irq_q, irq_d;
  logic [7:0] rd_q, rd_d;
  logic run, src_tick, tick;
  cat_pkg::cat_tb_t sel;

  assign sel = cat_pkg::cat_tb_t'(mode_q[`CAT_MODE_SEL_HI:`CAT_MODE_SEL_LO]);

  always_comb begin
    case (sel)
      cat_pkg::CAT_TB_DIV12: src_tick = slow_tick;
      cat_pkg::CAT_TB_DIV4: src_tick = fast_tick;
      cat_pkg::CAT_TB_TMR0: src_tick = timer0_ovf;
      cat_pkg::CAT_TB_EXT: src_tick = ext_tick;
      cat_pkg::CAT_TB_SYS: src_tick = 1'b1;
      cat_pkg::CAT_TB_OSC8: src_tick = osc_tick;
      default: src_tick = 1'b0;
    endcase
    // idle only stops the count when suspend is requested
    run = cr_q && !(mode_q[`CAT_MODE_IDLE] && cpu_idle);
    tick = run && src_tick;

    count_d = count_q;
    if (tick) begin
      count_d = count_q + `CAT_CNT_ONE;
    end
    // a software write wins over a same-cycle tick for the byte written only; reads never touch it
    if (wr_lo) begin
      count_d[7:0] = bus.wdata;
    end
    if (wr_hi) begin
      count_d[15:8] = bus.wdata;
    end

    snap_d = rd_lo ? count_q[15:8] : snap_q;

    // flag cleared by writing one; a same-cycle wrap still sets it
    ovf_flag_d = ovf_flag_q;
    if (wr_ctrl && bus.wdata[`CAT_CTRL_OVF]) begin
      ovf_flag_d = 1'b0;
    end
    if (tick && count_q == `CAT_CNT_MAX) begin
      ovf_flag_d = 1'b1;
    end
    cr_d = wr_ctrl ? bus.wdata[`CAT_CTRL_CR] : cr_q;
    mode_d = mode_q;
    if (wr_mode) begin
      // unused mode bits are kept at zero so they read back as zero
      mode_d = bus.wdata & `CAT_MODE_MASK;
    end

    // level request, held while the flag stays set and the overflow, global and array enables are all on
    irq_d = ovf_flag_q && mode_q[`CAT_MODE_OVF_IE]
      && global_irq_enable && array_irq_enable;

    rd_d = `CAT_READ_ZERO;
    if (bus.rd) begin
      if (hit(bus.addr, `CAT_ADDR_CTRL)) begin
        rd_d[`CAT_CTRL_OVF] = ovf_flag_q;
        rd_d[`CAT_CTRL_CR] = cr_q;
      end else if (hit(bus.addr, `CAT_ADDR_MODE)) begin
        rd_d = mode_q;
      end else if (hit(bus.addr, `CAT_ADDR_CNT_LO)) begin
        rd_d = count_q[7:0];
      end else if (hit(bus.addr, `CAT_ADDR_CNT_HI)) begin
        rd_d = snap_q;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_q <= `CAT_CNT_RESET;
      snap_q <= `CAT_REG_RESET;
      mode_q <= `CAT_REG_RESET;
      ovf_flag_q <= 1'b0;
      cr_q <= 1'b0;
      irq_q <= 1'b0;
      rd_q <= `CAT_READ_ZERO;
    end else begin
      count_q <= count_d;
      snap_q <= snap_d;
      mode_q <= mode_d;
      ovf_flag_q <= ovf_flag_d;
      cr_q <= cr_d;
      irq_q <= irq_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign irq = irq_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wrap;
    tick && count_q == `CAT_CNT_MAX && !wr_lo && !wr_hi;
  endsequence

  sequence s_plain_tick;
    tick && !wr_lo && !wr_hi;
  endsequence

  sequence s_idle_tick;
    !tick && !wr_lo && !wr_hi;
  endsequence

  a_wrap_sets_flag: assert property (
    s_wrap |=> ovf_flag_q && count_q == `CAT_CNT_RESET)
    else $error("wrap did not set overflow flag");

  a_count_step: assert property (
    s_plain_tick |=> count_q == $past(count_q) + `CAT_CNT_ONE)
    else $error("count did not step by one");

  a_count_hold: assert property (
    s_idle_tick |=> $stable(count_q))
    else $error("count moved without a tick");

  a_read_no_disturb: assert property (
    (rd_lo || rd_hi) ##0 s_idle_tick |=> $stable(count_q))
    else $error("read disturbed the count");

  a_snapshot_read: assert property (
    rd_lo ##1 rd_hi |=> rd_q == $past(count_q[15:8], 2))
    else $error("high read did not return snapshot");

  a_irq_gating: assert property (
    irq_q |-> $past(ovf_flag_q && mode_q[`CAT_MODE_OVF_IE]))
    else $error("irq without enabled flag");

  a_irq_global: assert property (
    !global_irq_enable || !array_irq_enable |=> !irq_q)
    else $error("irq with global enables off");

  a_flag_sticky: assert property (
    ovf_flag_q && !(wr_ctrl && bus.wdata[`CAT_CTRL_OVF]) |=> ovf_flag_q)
    else $error("overflow flag lost without clear");

  a_idle_suspend: assert property (
    cpu_idle && !mode_q[`CAT_MODE_IDLE] && cr_q && sel == cat_pkg::CAT_TB_SYS |-> tick)
    else $error("counting stopped in idle without suspend");

  a_div12_gap: assert property (
    sel == cat_pkg::CAT_TB_DIV12 && tick |=> !slow_tick [*8])
    else $error("slow timebase ticked too early");

  a_ext_edge: assert property (
    sel == cat_pkg::CAT_TB_EXT && run && ext_prev_q && !external_count_input |-> tick)
    else $error("falling edge not counted");

  // read steps of the two-byte count
  sequence s_lo_read;
    rd_lo;
  endsequence

  sequence s_hi_read;
    rd_hi;
  endsequence

  a_hi_read_data: assert property (
    s_hi_read |=> rd_q == $past(snap_q))
    else $error("high read not from snapshot");

  a_snap_capture: assert property (
    s_lo_read |=> snap_q == $past(count_q[15:8]))
    else $error("low read did not latch high byte");

  a_snap_hold: assert property (
    !rd_lo |=> $stable(snap_q))
    else $error("snapshot changed without low read");

  a_lo_read_data: assert property (
    rd_lo |=> rd_q == $past(count_q[7:0]))
    else $error("low read returned wrong byte");

  a_write_lo: assert property (
    wr_lo |=> count_q[7:0] == $past(bus.wdata))
    else $error("low byte write lost");

  // read data stand for one cycle only, so a stale byte never reads twice
  a_rd_idle_zero: assert property (
    !bus.rd |=> rd_q == `CAT_READ_ZERO)
    else $error("read data not zero when idle");

  a_flag_clear: assert property (
    ovf_flag_q && wr_ctrl && bus.wdata[`CAT_CTRL_OVF] && !(tick && count_q == `CAT_CNT_MAX)
      |=> !ovf_flag_q)
    else $error("overflow flag not cleared");

  a_flag_no_false: assert property (
    !ovf_flag_q && !(tick && count_q == `CAT_CNT_MAX) |=> !ovf_flag_q)
    else $error("overflow flag set without wrap");

  a_irq_level: assert property (
    ovf_flag_q && mode_q[`CAT_MODE_OVF_IE] && global_irq_enable && array_irq_enable |=> irq_q)
    else $error("enabled overflow gave no irq");

  a_stop_holds: assert property (
    !cr_q && !wr_lo && !wr_hi |=> $stable(count_q))
    else $error("stopped counter moved");

  a_idle_stops: assert property (
    cpu_idle && mode_q[`CAT_MODE_IDLE] && !wr_lo && !wr_hi |=> $stable(count_q))
    else $error("counter ran in suspended idle");

  a_sys_every: assert property (
    cr_q && !cpu_idle && sel == cat_pkg::CAT_TB_SYS |-> tick)
    else $error("system clock timebase missed a tick");

  a_div4_gap: assert property (
    sel == cat_pkg::CAT_TB_DIV4 && tick |=> !fast_tick [*3])
    else $error("fast timebase ticked too early");

  a_tmr0_follow: assert property (
    sel == cat_pkg::CAT_TB_TMR0 && run |-> tick == timer0_ovf)
    else $error("timer overflow not followed");

  // the divided oscillator may only step on a resynchronised edge
  a_osc_sync: assert property (
    osc_tick |-> osc_s2_q && !osc_s3_q)
    else $error("oscillator tick without synchronised edge");

  a_ext_no_rise: assert property (
    sel == cat_pkg::CAT_TB_EXT && !(ext_prev_q && !external_count_input) |-> !tick)
    else $error("count without falling edge");

endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
  self-checking bench for cat_timebase: register reads and writes, all
  timebases, overflow flag and interrupt gating.
  assumes cat_defs.svh offsets and a 200 MHz sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cat_defs.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end

module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  cat_pkg::cat_bus_t bus = '0;
  logic [7:0] rd_data;
  logic t0 = 1'b0;
  logic ext_in = 1'b1;
  logic osc = 1'b0;
  logic idle = 1'b0;
  logic gie = 1'b0;
  logic aie = 1'b0;
  logic irq;
  int err_total = 0;
  int n_tests = 0;
  logic [15:0] c;
  logic [7:0] d;

  always #2.5 sys_clk = ~sys_clk;

  cat_timebase i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .timer0_ovf(t0), .external_count_input(ext_in), .osc_clk(osc), .cpu_idle(idle),
    .global_irq_enable(gie), .array_irq_enable(aie), .irq(irq));

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
    @(posedge sys_clk);
    #1 `CHK("rd idle", 8'h00, rd_data)
    @(posedge sys_clk);
  endtask

  // low then high on back-to-back strobes
  task automatic rd16(output logic [15:0] v);
    @(posedge sys_clk);
    bus <= '{addr: `CAT_ADDR_CNT_LO, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.addr <= `CAT_ADDR_CNT_HI;
    #1 v[7:0] = rd_data;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1 v[15:8] = rd_data;
    @(posedge sys_clk);
  endtask

  task automatic load(input logic [15:0] v);
    wr(`CAT_ADDR_CNT_LO, v[7:0]);
    wr(`CAT_ADDR_CNT_HI, v[15:8]);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk) t0 <= 1'b1;
      @(posedge sys_clk) t0 <= 1'b0;
    end
  endtask

  task automatic wait_chk_irq(input logic e);
    repeat (3) @(posedge sys_clk);
    #1 `CHK("irq", e, irq)
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rd(`CAT_ADDR_CTRL, d); `CHK("ctrl", 8'h00, d)
    rd(`CAT_ADDR_MODE, d); `CHK("mode", 8'h00, d)
    rd(8'h00, d); `CHK("unmapped", 8'h00, d)
    rd(`CAT_ADDR_CNT_HI, d); `CHK("snap reset", 8'h00, d)
  endtask

  task automatic t_timer0;
    wr(`CAT_ADDR_MODE, 8'h04);
    load(16'h12fe);
    wr(`CAT_ADDR_CTRL, 8'h40);
    pulse(3);
    wr(`CAT_ADDR_CTRL, 8'h00);
    rd16(c); `CHK("t0 count", 16'h1301, c)
  endtask

  task automatic t_snap;
    load(16'h5a33);
    rd(`CAT_ADDR_CNT_LO, d); `CHK("lo", 8'h33, d)
    wr(`CAT_ADDR_CNT_HI, 8'hc7);
    rd(`CAT_ADDR_CNT_HI, d); `CHK("snapshot", 8'h5a, d)
    rd16(c); `CHK("reread", 16'hc733, c)
  endtask

  task automatic t_ovf;
    wr(`CAT_ADDR_MODE, 8'h05);
    gie <= 1'b1;
    aie <= 1'b1;
    load(16'hffff);
    wr(`CAT_ADDR_CTRL, 8'h40);
    pulse(1);
    wr(`CAT_ADDR_CTRL, 8'h00);
    rd16(c); `CHK("wrap", 16'h0000, c)
    rd(`CAT_ADDR_CTRL, d); `CHK("flag", 8'h80, d)
    wait_chk_irq(1'b1);
    gie <= 1'b0;
    wait_chk_irq(1'b0);
    gie <= 1'b1;
    aie <= 1'b0;
    wait_chk_irq(1'b0);
    aie <= 1'b1;
    wr(`CAT_ADDR_MODE, 8'h04);
    wait_chk_irq(1'b0);
    wr(`CAT_ADDR_MODE, 8'h05);
    wait_chk_irq(1'b1);
    wr(`CAT_ADDR_CTRL, 8'h80);
    rd(`CAT_ADDR_CTRL, d); `CHK("cleared", 8'h00, d)
    wait_chk_irq(1'b0);
  endtask

  // falling edges every fourth cycle: the fastest rate allowed
  task automatic t_ext;
    wr(`CAT_ADDR_MODE, 8'h06);
    load(16'h0000);
    wr(`CAT_ADDR_CTRL, 8'h40);
    repeat (3) begin
      repeat (2) @(posedge sys_clk) ext_in <= 1'b0;
      repeat (2) @(posedge sys_clk) ext_in <= 1'b1;
    end
    wr(`CAT_ADDR_CTRL, 8'h00);
    rd16(c); `CHK("ext", 16'h0003, c)
  endtask

  task automatic t_osc;
    wr(`CAT_ADDR_MODE, 8'h0a);
    load(16'h0000);
    wr(`CAT_ADDR_CTRL, 8'h40);
    repeat (16) begin
      repeat (2) @(posedge sys_clk) osc <= 1'b1;
      repeat (2) @(posedge sys_clk) osc <= 1'b0;
    end
    repeat (6) @(posedge sys_clk);
    wr(`CAT_ADDR_CTRL, 8'h00);
    rd16(c); `CHK("osc", 16'h0002, c)
  endtask

  // window edges are only known to about one cycle, so a band is accepted
  task automatic t_div;
    logic [2:0] sel [3];
    int dv [3];
    sel = '{3'h0, 3'h1, 3'h4};
    dv = '{12, 4, 1};
    for (int i = 0; i < 3; i++) begin
      wr(`CAT_ADDR_MODE, {4'h0, sel[i], 1'b0});
      load(16'h0000);
      wr(`CAT_ADDR_CTRL, 8'h40);
      repeat (10 * dv[i] - 2) @(posedge sys_clk);
      wr(`CAT_ADDR_CTRL, 8'h00);
      rd16(c); `CHK("div", 1'b1, (c >= 16'h0009 && c <= 16'h000b))
    end
  endtask

  task automatic t_idle;
    wr(`CAT_ADDR_MODE, 8'h84);
    load(16'h0000);
    idle <= 1'b1;
    wr(`CAT_ADDR_CTRL, 8'h40);
    pulse(2);
    rd16(c); `CHK("suspended", 16'h0000, c)
    wr(`CAT_ADDR_MODE, 8'h04);
    pulse(2);
    wr(`CAT_ADDR_CTRL, 8'h00);
    rd16(c); `CHK("idle run", 16'h0002, c)
    idle <= 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer0();
    t_snap();
    t_ovf();
    t_ext();
    t_osc();
    t_div();
    t_idle();
    close_out();
  end

  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
